// ===== avr_pkg.sv
// constants, types and settings tables for the voltage regulating block
package avr_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_EDIT = 8'h04;
  localparam logic [7:0] ADR_KEY = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0c;
  localparam logic [7:0] ADR_SETTING = 8'h10;
  localparam logic [7:0] ADR_PRIMARY = 8'h14;
  localparam logic [7:0] ADR_SECONDARY = 8'h18;
  // key register fields
  localparam int KEY_IDX_LSB = 0;
  localparam int KEY_ACT_LSB = 4;
  localparam logic [2:0] ACT_SELECT = 3'h1;
  localparam logic [2:0] ACT_LI = 3'h2;
  localparam logic [2:0] ACT_POL = 3'h3;
  localparam logic [2:0] ACT_ENTER = 3'h4;
  // setting indices
  localparam int NSET = 10;
  localparam logic [3:0] SET_NS = 4'h0;
  localparam logic [3:0] SET_RS = 4'h1;
  localparam logic [3:0] SET_LS = 4'h2;
  localparam logic [3:0] SET_UV = 4'h3;
  localparam logic [3:0] SET_OV = 4'h4;
  localparam logic [3:0] SET_KV = 4'h5;
  localparam logic [3:0] SET_T1 = 4'h6;
  localparam logic [3:0] SET_T2 = 4'h7;
  localparam logic [3:0] SET_CR = 4'h8;
  localparam logic [3:0] SET_CX = 4'h9;
  localparam logic [3:0] SEL_LI = 4'ha;
  // volts in 0.1 v, percent in 0.1 %, kv in 0.1 kv, delays in s; index 9 first
  localparam logic [159:0] SET_MIN = {16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000,
    16'h041a, 16'h0258, 16'h0005, 16'h0005, 16'h0352};
  localparam logic [159:0] SET_MAX = {16'h00c8, 16'h00c8, 16'h000b, 16'h00b4, 16'h270f,
    16'h0514, 16'h03b6, 16'h005a, 16'h005a, 16'h0578};
  localparam logic [159:0] SET_RST = {16'h0000, 16'h0000, 16'h000a, 16'h001e, 16'h044c,
    16'h044c, 16'h0320, 16'h0014, 16'h0014, 16'h044c};
  // unit per selection, index 10 first: 0 volt, 1 kv, 2 percent, 3 seconds
  localparam logic [21:0] SET_UNIT = {2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h0};
  localparam logic [15:0] T2_OFF = 16'h000b;
  localparam logic [15:0] PCT_DEN = 16'h03e8;
  localparam logic [15:0] RESTORE_PM = 16'h0032;
  // timing
  localparam int CLK_HZ = 125000000;
  localparam int PULSE_S = 2;
  localparam int FAST_S = 2;
  typedef struct packed {
    logic raise;
    logic lower;
    logic uv;
    logic ov;
  } relay_t;
  typedef struct packed {
    logic volt;
    logic kv;
    logic pct;
    logic sec;
  } unit_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT1, ST_PULSE, ST_GAP, ST_HOLD, ST_FAST_ON, ST_FAST_OFF
  } reg_state_t;
endpackage

// ===== avr_regulator.sv
// tap changer voltage regulation decision logic with wishbone settings access
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
module avr_regulator
  import avr_pkg::*;
#(
  parameter int CYCLES_PER_SEC = CLK_HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // measured secondary voltage, 0.1 v units
  input wire logic [15:0] volt_sample,
  input wire logic sample_valid,
  input wire logic line_drop_comp_option,
  // relays and indicators
  output relay_t relays,
  output unit_t unit_leds,
  output logic manual_led
);

  function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] p);
    logic [31:0] prod;
    prod = base * p;
    pct_of = 16'(prod / 32'(PCT_DEN));
  endfunction

  function automatic logic in_range(input logic [3:0] idx, input logic [15:0] val);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = SET_MIN[{idx, 4'h0} +: 16];
    hi = SET_MAX[{idx, 4'h0} +: 16];
    in_range = (val >= lo) && (val <= hi);
  endfunction

  // registers
  logic ack_r;
  logic [31:0] dat_r;
  logic manual_r;
  logic [15:0] nonvolatile_store [NSET];
  logic mode_int_r;
  logic [1:0] pol_r;
  logic [3:0] sel_r;
  logic [15:0] edit_r;
  logic shown_li_r;
  logic shown_pol_r;
  logic edit_err_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] volt_r;
  logic samp_r;
  logic need_raise_r;
  logic need_lower_r;
  logic uv_blk_r;
  logic ov_r;
  logic [15:0] primary_r;
  reg_state_t state_r;
  reg_state_t state_nxt;
  logic dir_raise_r;
  logic dir_raise_nxt;
  logic [15:0] sec_r;
  relay_t relays_r;
  unit_t units_r;

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire bus_wr = bus_req && wb_we_i;
  wire wr_ctrl = bus_wr && (wb_adr_i == ADR_CTRL) && wb_sel_i[0];
  wire wr_edit_lo = bus_wr && (wb_adr_i == ADR_EDIT) && wb_sel_i[0];
  wire wr_edit_hi = bus_wr && (wb_adr_i == ADR_EDIT) && wb_sel_i[1];
  wire wr_key = bus_wr && (wb_adr_i == ADR_KEY) && wb_sel_i[0];
  wire [3:0] key_idx = wb_dat_i[KEY_IDX_LSB +: 4];
  wire [2:0] key_act = wb_dat_i[KEY_ACT_LSB +: 3];

  // stored settings
  wire [15:0] ns_v = nonvolatile_store[SET_NS];
  wire [15:0] rs_v = nonvolatile_store[SET_RS];
  wire [15:0] ls_v = nonvolatile_store[SET_LS];
  wire [15:0] t1_v = nonvolatile_store[SET_T1];
  wire [15:0] t2_v = nonvolatile_store[SET_T2];
  wire sel_is_set = sel_r < SEL_LI;
  wire sel_is_comp = (sel_r == SET_CR) || (sel_r == SET_CX);
  wire [15:0] sel_val = sel_is_set ? nonvolatile_store[sel_r] : 16'h0000;
  wire sel_pol = (sel_r == SET_CX) ? pol_r[1] : pol_r[0];

  // thresholds in fixed point
  wire [15:0] raise_band = pct_of(ns_v, rs_v);
  wire [15:0] lower_band = pct_of(ns_v, ls_v);
  wire [15:0] raise_lim = ns_v - raise_band;
  wire [15:0] lower_lim = ns_v + lower_band;
  wire [15:0] uv_lim = pct_of(ns_v, nonvolatile_store[SET_UV]);
  wire [15:0] uv_rel = uv_lim + pct_of(uv_lim, RESTORE_PM);
  wire [15:0] ov_lim = pct_of(ns_v, nonvolatile_store[SET_OV]);
  wire [15:0] ov_rel = ov_lim - pct_of(ov_lim, RESTORE_PM);
  wire [31:0] prim_prod = volt_r * nonvolatile_store[SET_KV];
  wire [15:0] prim_calc = 16'(prim_prod / {16'h0000, ns_v});

  // first-pulse and inter-pulse delays
  wire [15:0] dev = dir_raise_r ? (ns_v - volt_r) : (volt_r - ns_v);
  wire [15:0] band = dir_raise_r ? raise_band : lower_band;
  wire [31:0] t1_prod = t1_v * band;
  wire [15:0] t1_int = (dev == 16'h0000) ? t1_v : 16'(t1_prod / {16'h0000, dev});
  wire [15:0] t1_int_c = (t1_int == 16'h0000) ? 16'h0001 : t1_int;
  wire [15:0] t1_eff = mode_int_r ? t1_int_c : t1_v;
  wire [15:0] gap_eff = (t2_v == T2_OFF) ? t1_eff : t2_v;
  wire t2_zero = t2_v == 16'h0000;
  wire raise_ok = need_raise_r && !uv_blk_r;
  wire cur_need = dir_raise_r ? raise_ok : need_lower_r;
  wire is_fast = (state_r == ST_FAST_ON) || (state_r == ST_FAST_OFF);
  wire drive = (state_r == ST_PULSE) || (state_r == ST_HOLD) || (state_r == ST_FAST_ON);

  // read mux
  wire [31:0] rd_status = {21'h000000, edit_err_r, uv_blk_r, ov_r, need_raise_r,
    need_lower_r, dir_raise_r, relays_r, 1'b0};
  wire comp_na = sel_is_comp && !line_drop_comp_option;
  wire [31:0] rd_setting = {13'h0000, comp_na, mode_int_r, sel_pol, sel_val};
  logic [31:0] rd_data;
  always_comb begin
    case (wb_adr_i)
      ADR_CTRL: rd_data = {31'h00000000, manual_r};
      ADR_EDIT: rd_data = {14'h0000, shown_pol_r, shown_li_r, edit_r};
      ADR_KEY: rd_data = {28'h0000000, sel_r};
      ADR_STATUS: rd_data = rd_status;
      ADR_SETTING: rd_data = rd_setting;
      ADR_PRIMARY: rd_data = {16'h0000, primary_r};
      ADR_SECONDARY: rd_data = {16'h0000, volt_r};
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      dat_r <= bus_req ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      manual_r <= 1'b0;
    end else if (wr_ctrl) begin
      manual_r <= wb_dat_i[0];
    end
  end

  // keypad actions and settings storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NSET; i++) begin
        nonvolatile_store[i] <= SET_RST[i*16 +: 16];
      end
      mode_int_r <= 1'b0;
      pol_r <= 2'h0;
      sel_r <= SET_NS;
      edit_r <= 16'h0000;
      shown_li_r <= 1'b0;
      shown_pol_r <= 1'b0;
      edit_err_r <= 1'b0;
    end else begin
      if (wr_edit_lo) begin
        edit_r[7:0] <= wb_dat_i[7:0];
      end
      if (wr_edit_hi) begin
        edit_r[15:8] <= wb_dat_i[15:8];
      end
      if (wr_key) begin
        case (key_act)
          ACT_SELECT: begin
            if (key_idx <= SEL_LI) begin
              sel_r <= key_idx;
              edit_err_r <= 1'b0;
              shown_li_r <= mode_int_r;
              shown_pol_r <= (key_idx == SET_CX) ? pol_r[1] : pol_r[0];
              edit_r <= (key_idx < SEL_LI) ? nonvolatile_store[key_idx] : 16'h0000;
            end
          end
          ACT_LI: begin
            if (sel_r == SEL_LI) begin
              shown_li_r <= !shown_li_r;
            end else begin
              sel_r <= SEL_LI;
              shown_li_r <= mode_int_r;
              edit_err_r <= 1'b0;
            end
          end
          ACT_POL: begin
            if (sel_is_comp && line_drop_comp_option) begin
              shown_pol_r <= !shown_pol_r;
            end
          end
          ACT_ENTER: begin
            if (sel_r == SEL_LI) begin
              mode_int_r <= shown_li_r;
            end else if (sel_is_comp && !line_drop_comp_option) begin
              edit_err_r <= 1'b0;
            end else if (in_range(sel_r, edit_r)) begin
              nonvolatile_store[sel_r] <= edit_r;
              edit_err_r <= 1'b0;
              if (sel_r == SET_CR) begin
                pol_r[0] <= shown_pol_r;
              end
              if (sel_r == SET_CX) begin
                pol_r[1] <= shown_pol_r;
              end
            end else begin
              edit_err_r <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // one second tick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (state_nxt != state_r) begin
      // restart the second on each state change so phases last whole seconds;
      // the preload covers the tick and seconds register stages
      tick_cnt_r <= 32'h00000002;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(CYCLES_PER_SEC - 1)) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // sample capture and threshold evaluation
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      volt_r <= 16'h0000;
      samp_r <= 1'b0;
      need_raise_r <= 1'b0;
      need_lower_r <= 1'b0;
      uv_blk_r <= 1'b0;
      ov_r <= 1'b0;
      primary_r <= 16'h0000;
    end else begin
      samp_r <= sample_valid;
      if (sample_valid) begin
        volt_r <= volt_sample;
      end
      if (samp_r) begin
        need_raise_r <= volt_r < raise_lim;
        need_lower_r <= volt_r > lower_lim;
        primary_r <= prim_calc;
        if (volt_r < uv_lim) begin
          uv_blk_r <= 1'b1;
        end else if (volt_r > uv_rel) begin
          uv_blk_r <= 1'b0;
        end
        if (volt_r > ov_lim) begin
          ov_r <= 1'b1;
        end else if (volt_r < ov_rel) begin
          ov_r <= 1'b0;
        end
      end
    end
  end

  // tap control sequencing
  always_comb begin
    state_nxt = state_r;
    dir_raise_nxt = dir_raise_r;
    if (ov_r && !is_fast) begin
      state_nxt = ST_FAST_ON;
      dir_raise_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (raise_ok) begin
            state_nxt = ST_WAIT1;
            dir_raise_nxt = 1'b1;
          end else if (need_lower_r) begin
            state_nxt = ST_WAIT1;
            dir_raise_nxt = 1'b0;
          end
        end
        ST_WAIT1: begin
          if (!cur_need) begin
            state_nxt = ST_IDLE;
          end else if (sec_r >= t1_eff) begin
            state_nxt = t2_zero ? ST_HOLD : ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (sec_r >= 16'(PULSE_S)) begin
            state_nxt = ST_GAP;
          end
        end
        ST_GAP: begin
          if (!cur_need) begin
            state_nxt = ST_IDLE;
          end else if (sec_r >= gap_eff) begin
            state_nxt = t2_zero ? ST_HOLD : ST_PULSE;
          end
        end
        ST_HOLD: begin
          if (!cur_need) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_FAST_ON: begin
          if (sec_r >= 16'(FAST_S)) begin
            state_nxt = ST_FAST_OFF;
          end
        end
        ST_FAST_OFF: begin
          if (sec_r >= 16'(FAST_S)) begin
            state_nxt = ov_r ? ST_FAST_ON : ST_GAP;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      dir_raise_r <= 1'b0;
      sec_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      dir_raise_r <= dir_raise_nxt;
      if (state_nxt != state_r) begin
        sec_r <= 16'h0000;
      end else if (tick_r && (sec_r != 16'hffff)) begin
        sec_r <= sec_r + 16'h0001;
      end
    end
  end

  // relay and indicator registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      relays_r <= '0;
      units_r <= '0;
    end else begin
      relays_r.raise <= drive && dir_raise_r && !is_fast && !manual_r;
      relays_r.lower <= drive && (!dir_raise_r || is_fast) && !manual_r;
      relays_r.uv <= uv_blk_r;
      relays_r.ov <= ov_r;
      units_r.volt <= SET_UNIT[{sel_r, 1'b0} +: 2] == 2'h0;
      units_r.kv <= SET_UNIT[{sel_r, 1'b0} +: 2] == 2'h1;
      units_r.pct <= SET_UNIT[{sel_r, 1'b0} +: 2] == 2'h2;
      units_r.sec <= SET_UNIT[{sel_r, 1'b0} +: 2] == 2'h3;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign relays = relays_r;
  assign unit_leds = units_r;
  assign manual_led = manual_r;

endmodule

// ===== avr_regulator_properties.sv
// concurrent checks on the regulator ports
`timescale 1ns/10ps
module avr_regulator_checker
  import avr_pkg::*;
#(
  parameter int CYCLES_PER_SEC = CLK_HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // samples and outputs
  input wire logic sample_valid,
  input wire relay_t relays,
  input wire logic manual_led
);
  localparam int FAST_CYC = FAST_S * CYCLES_PER_SEC;
  int run_len;
  logic run_ov;
  logic man_d;
  // length of the current lower run and whether it began in overvoltage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_len <= 0;
      run_ov <= 1'b0;
      man_d <= 1'b0;
    end else begin
      man_d <= manual_led;
      run_len <= relays.lower ? run_len + 1 : 0;
      // man_d is already low when a run's first cycle is latched, so a run that starts as manual mode ends is still timed
      if (run_len == 0) run_ov <= relays.ov && !man_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o; endsequence
  property p_ack_resp; s_req |=> s_ack; endproperty
  property p_ack_pulse; s_ack |=> !wb_ack_o; endproperty
  property p_dat_zero; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_excl; !(relays.raise && relays.lower); endproperty
  property p_manual; manual_led && $past(manual_led) |-> !relays.raise && !relays.lower;
  endproperty
  property p_raise_uv; $rose(relays.raise) |-> !relays.uv; endproperty
  property p_uv_cause; $rose(relays.uv) |-> $past(sample_valid, 1) || $past(sample_valid, 2)
    || $past(sample_valid, 3) || $past(sample_valid, 4); endproperty
  property p_fast_width; $fell(relays.lower) && run_ov |-> run_len == FAST_CYC; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_zero: assert property (p_dat_zero) else $error("read data not zero without ack");
  a_excl: assert property (p_excl) else $error("raise and lower together");
  a_manual: assert property (p_manual) else $error("relay active in manual mode");
  a_raise_uv: assert property (p_raise_uv) else $error("raise started while blocked");
  a_uv_cause: assert property (p_uv_cause) else $error("uv set without a sample");
  a_fast_width: assert property (p_fast_width) else $error("fast lower width wrong");
endmodule
bind avr_regulator avr_regulator_checker #(.CYCLES_PER_SEC(CYCLES_PER_SEC)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_valid(sample_valid), .relays(relays),
  .manual_led(manual_led));

// ===== pt_tap_model.sv
// pt sample source facing the regulator
`timescale 1ns/10ps
module pt_tap_model
  import avr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // requested secondary voltage
  input wire logic [15:0] target_volt,
  // sample stream
  output logic [15:0] volt_sample,
  output logic sample_valid
);
  logic [1:0] phase_r;
  // one sample every four cycles; the bus carries junk between samples
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= 2'h0;
      sample_valid <= 1'b0;
      volt_sample <= 16'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      sample_valid <= (phase_r == 2'h3);
      volt_sample <= (phase_r == 2'h3) ? target_volt : ~target_volt;
    end
  end
endmodule

// ===== avr_regulator_tb_top.sv
// self-checking bench for the voltage regulating block
`timescale 1ns/10ps
module avr_regulator_tb_top
  import avr_pkg::*;
;
  typedef struct packed {logic chk; logic [31:0] val; logic [31:0] msk;} note_t;
  logic ref_clk, reset_n, cyc, stb, we, ack, sv, man, opt;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [15:0] tgt, vs;
  relay_t rel;
  unit_t led;
  int n_mismatch, tests_run, n, v;
  note_t q[$];
  note_t nt;
  avr_regulator #(.CYCLES_PER_SEC(10)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .volt_sample(vs), .sample_valid(sv),
    .line_drop_comp_option(opt), .relays(rel), .unit_leds(led), .manual_led(man));
  pt_tap_model pt (.ref_clk(ref_clk), .reset_n(reset_n), .target_volt(tgt),
    .volt_sample(vs), .sample_valid(sv));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_in(input int c, input int lo, input int hi);
    check(32'(c >= lo && c <= hi), 32'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [31:0] m);
    int k;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    q.push_back('{!w, e, m});
    k = 0;
    do begin @(posedge ref_clk); k++; end while (ack !== 1'b1 && k < 50);
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 50) n_mismatch++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d, 0, 0); endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, 32'h0, e, m);
  endtask
  task automatic key(input logic [3:0] i, input logic [2:0] act);
    wr(ADR_KEY, {25'h0, act, i});
  endtask
  task automatic setv(input logic [3:0] i, input logic [15:0] val);
    key(i, ACT_SELECT); wr(ADR_EDIT, {16'h0, val}); key(i, ACT_ENTER);
  endtask
  // count cycles while relay bit b stays at level l, up to lim
  task automatic meas(input int b, input logic l, input int lim, output int c);
    c = 0;
    while (rel[b] === l && c < lim) begin @(negedge ref_clk); c++; end
  endtask
  task automatic inband(); tgt <= 16'd1080 + 16'($urandom % 40); endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) if (ack === 1'b1 && q.size() > 0) begin
    nt = q.pop_front();
    if (nt.chk) check(rdat & nt.msk, nt.val);
  end
  initial begin ref_clk = 1'b0; forever #4 ref_clk = ~ref_clk; end
  initial begin #400000; n_mismatch++; report_and_stop(); end
  initial begin
    reset_n = 0; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0; tgt = 16'h044c; opt = 1;
    n_mismatch = 0; tests_run = 0;
    v = $urandom(32'h92cff8c9);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i <= 10; i++) begin
      key(4'(i), ACT_SELECT);
      rd(ADR_SETTING, (i < 10) ? {16'h0, SET_RST[16*i+:16]} : 32'h0, 32'hffff);
      check({28'h0, led}, {28'h0, 4'h8 >> SET_UNIT[2*i+:2]});
    end
    setv(SET_NS, 16'h0351); rd(ADR_STATUS, 32'h400, 32'h400);
    rd(ADR_SETTING, 32'h44c, 32'hffff);
    setv(SET_NS, 16'h0578); rd(ADR_SETTING, 32'h578, 32'hffff);
    rd(ADR_STATUS, 32'h0, 32'h400);
    setv(SET_NS, 16'h044c); setv(SET_T1, 16'h000a); rd(8'h1c, 32'h0, 32'hffffffff);
    setv(SET_CR, 16'h00c8); key(SET_CR, ACT_POL); rd(ADR_EDIT, 32'h20000, 32'h20000);
    rd(ADR_SETTING, 32'h000c8, 32'h1ffff);
    key(SET_CR, ACT_ENTER); rd(ADR_SETTING, 32'h10000, 32'h10000);
    opt <= 1'b0; key(SET_CX, ACT_SELECT); rd(ADR_SETTING, 32'h40000, 32'h40000);
    opt <= 1'b1; setv(SET_CR, 16'h0);
    tgt <= 16'd1050; meas(3, 0, 300, n); chk_in(n, 96, 110);
    meas(3, 1, 100, n); chk_in(n, 20, 20);
    meas(3, 0, 300, n); chk_in(n, 96, 104);
    inband(); meas(3, 1, 30, n);
    tgt <= 16'd1050; repeat (50) @(posedge ref_clk); inband();
    meas(3, 0, 250, n); chk_in(n, 250, 250);
    key(SET_NS, ACT_LI); key(SEL_LI, ACT_LI); rd(ADR_EDIT, 32'h10000, 32'h10000);
    rd(ADR_SETTING, 32'h0, 32'h20000);
    key(SEL_LI, ACT_ENTER); rd(ADR_SETTING, 32'h20000, 32'h20000);
    tgt <= 16'd1155; meas(2, 0, 300, n); chk_in(n, 36, 50);
    inband(); meas(2, 1, 30, n);
    setv(SET_T2, 16'h0); tgt <= 16'd1050; meas(3, 0, 300, n);
    meas(3, 1, 200, n); chk_in(n, 200, 200);
    inband(); meas(3, 1, 30, n); setv(SET_T2, 16'h000a);
    tgt <= 16'd800; meas(1, 0, 20, n); meas(3, 0, 150, n); chk_in(n, 150, 150);
    tgt <= 16'd910; repeat (20) @(negedge ref_clk); check(32'(rel.uv), 32'h1);
    tgt <= 16'd950; meas(1, 1, 20, n); chk_in(n, 0, 19);
    inband(); meas(3, 1, 30, n);
    tgt <= 16'd1300; meas(0, 0, 20, n); meas(2, 0, 20, n); chk_in(n, 0, 19);
    meas(2, 1, 40, n); chk_in(n, 20, 20);
    meas(2, 0, 40, n); chk_in(n, 20, 20);
    tgt <= 16'd1160; meas(2, 1, 40, n); meas(2, 0, 40, n); chk_in(n, 20, 20);
    inband(); meas(0, 1, 60, n); chk_in(n, 0, 59);
    meas(2, 1, 30, n);
    wr(ADR_CTRL, 32'h1); check(32'(man), 32'h1);
    tgt <= 16'd1300; meas(0, 0, 20, n); check(32'(rel.ov), 32'h1);
    meas(2, 0, 80, n); chk_in(n, 80, 80);
    wr(ADR_CTRL, 32'h0); inband(); meas(0, 1, 60, n);
    v = 1080 + $urandom % 40; tgt <= 16'(v); repeat (10) @(posedge ref_clk);
    rd(ADR_PRIMARY, 32'(v), 32'hffff);
    rd(ADR_SECONDARY, 32'(v), 32'hffff);
    repeat (4) @(posedge ref_clk);
    report_and_stop();
  end
endmodule
